// ==== core/uart_channel.sv ====
// Contract
// - with divisor access off, reading address 0 returns the received character
// - with divisor access off, writing address 0 loads the transmit holding byte
// - address 2 read gives pending flag in bit 0, source in bits 1-3
// - address 2 write sets queue enable, queue resets and trigger level
// - line format bit 7 maps addresses 0 and 1 to the divisor latch
// - data bit 0 is least significant and first on the wire
// - in xt mode transmitter idle follows only the shift register
// - scratch byte at address 7 is absent in xt mode
// - with queues disabled the queue-only status bits read zero
// - the dma select bit of queue control does nothing
// - user outputs a and b drive no pin; in loop mode they feed ri and dcd
// - line state resets to all zeros except bits 5 and 6
// - identification resets to 01h, nothing pending
// - line status interrupt wins over received data interrupt
// - holding-empty interrupt clears on holding write or on an identification read that reports it
`timescale 1ns/1ps
module uart_channel (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic xtMode,
  input wire logic rxd,
  input wire logic ctsN,
  input wire logic dsrN,
  input wire logic riN,
  input wire logic dcdN,
  output logic txd,
  output logic dtrN,
  output logic rtsN,
  output logic irq
);
  typedef struct packed {
    logic [7:0] irqEnable;
    logic [7:0] lineFmt;
    logic [7:0] modemCtl;
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic [7:0] scratch;
    logic queueOn;
    logic [1:0] trigger;
    logic [7:0] rxBuf;
    logic [7:0] txHold;
    logic txFull;
    logic rxReady;
    logic overrun;
    logic parityFault;
    logic framingFault;
    logic breakSeen;
    logic txIrqPend;
    logic [3:0] modemDelta;
    logic [3:0] modemPrev;
    logic [3:0] evStat;
    logic [3:0] evEn;
    logic [7:0] rdata;
    logic irq;
    logic txd;
    logic dtrN;
    logic rtsN;
  } chan_state_t;

  chan_state_t s_q;
  chan_state_t s_d;
  uart_pkg::line_cfg_t cfg;
  uart_pkg::rx_char_t rxChar;
  logic txLoad;
  logic txBusy;
  logic txLine;
  logic rxLine;
  logic divAccess;
  logic [3:0] modemNow;
  logic [3:0] iirCode;
  logic lineErr;
  logic txIdle;
  logic [7:0] lineState;
  logic [7:0] modemState;
  logic [7:0] identify;

  // line configuration handed to the serial engine
  always_comb begin
    cfg.divisor = {s_q.divHigh, s_q.divLow};
    cfg.charLen = s_q.lineFmt[1:0];
    cfg.stopTwo = s_q.lineFmt[uart_pkg::LCR_STOP];
    cfg.parityOn = s_q.lineFmt[uart_pkg::LCR_PARITY];
    cfg.evenPar = s_q.lineFmt[uart_pkg::LCR_EVEN];
    cfg.stickPar = s_q.lineFmt[uart_pkg::LCR_STICK];
    cfg.breakOn = s_q.lineFmt[uart_pkg::LCR_BREAK];
  end

  // loop mode feeds the transmitter back and keeps the pin idle
  assign rxLine = s_q.modemCtl[uart_pkg::MCR_LOOP] ? txLine : rxd;
  assign divAccess = s_q.lineFmt[uart_pkg::LCR_DIV_ACCESS];
  // holding byte moves to the shifter whenever it is free
  assign txLoad = s_q.txFull && !txBusy;

  uart_serial serialEngine (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cfg(cfg),
    .txLoad(txLoad),
    .txData(s_q.txHold),
    .rxIn(rxLine),
    .txOut(txLine),
    .txBusy(txBusy),
    .rxChar(rxChar)
  );

  // modem inputs as {dcd, ri, dsr, cts}, looped from control in loop mode
  always_comb begin
    if (s_q.modemCtl[uart_pkg::MCR_LOOP])
      modemNow = {s_q.modemCtl[3], s_q.modemCtl[2], s_q.modemCtl[0], s_q.modemCtl[1]};
    else
      modemNow = {~dcdN, ~riN, ~dsrN, ~ctsN};
  end

  // status views built from live state
  always_comb begin
    lineErr = s_q.overrun | s_q.parityFault | s_q.framingFault | s_q.breakSeen;
    // xt mode ignores the holding byte for idle
    if (xtMode)
      txIdle = !txBusy;
    else
      txIdle = !txBusy && !s_q.txFull;
    lineState = {s_q.queueOn & lineErr, txIdle, !s_q.txFull, s_q.breakSeen,
      s_q.framingFault, s_q.parityFault, s_q.overrun, s_q.rxReady};
    modemState = {modemNow, s_q.modemDelta};
  end

  // interrupt source by priority, highest first
  always_comb begin
    if (s_q.irqEnable[uart_pkg::IER_LINE] && lineErr)
      iirCode = uart_pkg::IIR_LINE;
    else if (s_q.irqEnable[uart_pkg::IER_RX] && s_q.rxReady)
      iirCode = uart_pkg::IIR_RX;
    else if (s_q.irqEnable[uart_pkg::IER_TX] && s_q.txIrqPend)
      iirCode = uart_pkg::IIR_TX;
    else if (s_q.irqEnable[uart_pkg::IER_MODEM] && (|s_q.modemDelta))
      iirCode = uart_pkg::IIR_MODEM;
    else
      iirCode = uart_pkg::IIR_NONE;
    // timeout bit 3 never raised here; upper two report queue enable
    identify = {s_q.queueOn, s_q.queueOn, 2'b00, iirCode};
  end

  // next state: register writes, read side effects, hardware events
  always_comb begin
    logic wrData;
    logic rdData;
    logic rdIdent;
    logic [3:0] modemChg;
    logic txEmptyRise;
    s_d = s_q;
    wrData = regWr && regAddr == uart_pkg::ADDR_DATA && !divAccess;
    rdData = regRd && regAddr == uart_pkg::ADDR_DATA && !divAccess;
    rdIdent = regRd && regAddr == uart_pkg::ADDR_IIR;
    txEmptyRise = txLoad;
    modemChg = modemNow ^ s_q.modemPrev;
    // ring only flags its trailing edge
    modemChg[2] = s_q.modemPrev[2] & ~modemNow[2];

    // clears from reads and writes come first so events below win
    if (rdData)
      s_d.rxReady = 1'b0;
    if (regRd && regAddr == uart_pkg::ADDR_LSR) begin
      s_d.overrun = 1'b0;
      s_d.parityFault = 1'b0;
      s_d.framingFault = 1'b0;
      s_d.breakSeen = 1'b0;
    end
    if (regRd && regAddr == uart_pkg::ADDR_MSR)
      s_d.modemDelta = 4'h0;
    if (wrData || (rdIdent && iirCode == uart_pkg::IIR_TX))
      s_d.txIrqPend = 1'b0;
    if (txLoad)
      s_d.txFull = 1'b0;

    if (regWr) begin
      unique case (regAddr)
        uart_pkg::ADDR_DATA: begin
          if (divAccess) begin
            s_d.divLow = regWdata;
          end else begin
            s_d.txHold = regWdata;
            s_d.txFull = 1'b1;
          end
        end
        uart_pkg::ADDR_IER: begin
          if (divAccess) begin
            s_d.divHigh = regWdata;
          end else begin
            s_d.irqEnable = regWdata & uart_pkg::IER_MASK;
            // enabling with the holding register empty raises at once
            if (regWdata[uart_pkg::IER_TX] && !s_q.irqEnable[uart_pkg::IER_TX] && !s_q.txFull)
              s_d.txIrqPend = 1'b1;
          end
        end
        uart_pkg::ADDR_IIR: begin
          s_d.queueOn = regWdata[uart_pkg::FCR_ENABLE];
          s_d.trigger = regWdata[7:6];
          // bit 3 selects dma, which does not exist; bits 4 and 5 unused
          if (regWdata[uart_pkg::FCR_RX_RESET])
            s_d.rxReady = 1'b0;
          if (regWdata[uart_pkg::FCR_TX_RESET])
            s_d.txFull = 1'b0;
        end
        uart_pkg::ADDR_LCR: s_d.lineFmt = regWdata;
        uart_pkg::ADDR_MCR: s_d.modemCtl = regWdata & uart_pkg::MCR_MASK;
        uart_pkg::ADDR_SCR: begin
          if (!xtMode)
            s_d.scratch = regWdata;
        end
        uart_pkg::ADDR_EV_CLR: s_d.evStat = s_q.evStat & ~regWdata[3:0];
        uart_pkg::ADDR_EV_EN: s_d.evEn = regWdata[3:0];
        default: ;
      endcase
    end

    // hardware events, applied after clears
    if (rxChar.valid) begin
      if (s_q.rxReady && !rdData)
        s_d.overrun = 1'b1;
      s_d.rxBuf = rxChar.data;
      s_d.rxReady = 1'b1;
      s_d.parityFault = s_d.parityFault | rxChar.parityErr;
      s_d.framingFault = s_d.framingFault | rxChar.frameErr;
      s_d.breakSeen = s_d.breakSeen | rxChar.breakErr;
    end
    if (txEmptyRise)
      s_d.txIrqPend = 1'b1;
    s_d.modemDelta = s_d.modemDelta | modemChg;
    s_d.modemPrev = modemNow;

    // sticky event bits, set wins over a clear in the same cycle
    if (rxChar.valid)
      s_d.evStat[uart_pkg::EV_RX] = 1'b1;
    if (txEmptyRise)
      s_d.evStat[uart_pkg::EV_TX] = 1'b1;
    if (rxChar.valid && (rxChar.parityErr | rxChar.frameErr | rxChar.breakErr | s_q.rxReady))
      s_d.evStat[uart_pkg::EV_LINE] = 1'b1;
    if (|modemChg)
      s_d.evStat[uart_pkg::EV_MODEM] = 1'b1;
    s_d.irq = |(s_d.evStat & s_d.evEn);

    // read data, valid the cycle after the strobe only
    s_d.rdata = uart_pkg::REG_ZERO;
    if (regRd) begin
      unique case (regAddr)
        uart_pkg::ADDR_DATA: s_d.rdata = divAccess ? s_q.divLow : s_q.rxBuf;
        uart_pkg::ADDR_IER: s_d.rdata = divAccess ? s_q.divHigh : s_q.irqEnable;
        uart_pkg::ADDR_IIR: s_d.rdata = identify;
        uart_pkg::ADDR_LCR: s_d.rdata = s_q.lineFmt;
        uart_pkg::ADDR_MCR: s_d.rdata = s_q.modemCtl;
        uart_pkg::ADDR_LSR: s_d.rdata = lineState;
        uart_pkg::ADDR_MSR: s_d.rdata = modemState;
        uart_pkg::ADDR_SCR: s_d.rdata = xtMode ? uart_pkg::REG_ZERO : s_q.scratch;
        uart_pkg::ADDR_EV_STAT: s_d.rdata = {4'h0, s_q.evStat};
        uart_pkg::ADDR_EV_EN: s_d.rdata = {4'h0, s_q.evEn};
        default: s_d.rdata = uart_pkg::REG_ZERO;
      endcase
    end

    // pins: line held high in loop mode, user outputs a/b drive nothing
    s_d.txd = s_q.modemCtl[uart_pkg::MCR_LOOP] ? 1'b1 : txLine;
    s_d.dtrN = s_q.modemCtl[uart_pkg::MCR_LOOP] | ~s_q.modemCtl[0];
    s_d.rtsN = s_q.modemCtl[uart_pkg::MCR_LOOP] | ~s_q.modemCtl[1];
  end

  // one register stage; line state reset falls out of empty holding and idle shifter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.txd <= 1'b1;
      s_q.dtrN <= 1'b1;
      s_q.rtsN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;
  assign txd = s_q.txd;
  assign dtrN = s_q.dtrN;
  assign rtsN = s_q.rtsN;
  assign irq = s_q.irq;
endmodule // uart_channel

// ==== core/uart_pkg.sv ====
package uart_pkg;
  // register offsets, low eight follow the channel map
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_IER = 4'h1;
  localparam logic [3:0] ADDR_IIR = 4'h2;
  localparam logic [3:0] ADDR_LCR = 4'h3;
  localparam logic [3:0] ADDR_MCR = 4'h4;
  localparam logic [3:0] ADDR_LSR = 4'h5;
  localparam logic [3:0] ADDR_MSR = 4'h6;
  localparam logic [3:0] ADDR_SCR = 4'h7;
  localparam logic [3:0] ADDR_EV_STAT = 4'h8;
  localparam logic [3:0] ADDR_EV_CLR = 4'h9;
  localparam logic [3:0] ADDR_EV_EN = 4'hA;

  // field positions
  localparam int LCR_DIV_ACCESS = 7;
  localparam int LCR_BREAK = 6;
  localparam int LCR_STICK = 5;
  localparam int LCR_EVEN = 4;
  localparam int LCR_PARITY = 3;
  localparam int LCR_STOP = 2;
  localparam int FCR_ENABLE = 0;
  localparam int FCR_RX_RESET = 1;
  localparam int FCR_TX_RESET = 2;
  localparam int MCR_LOOP = 4;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;

  // writable masks, upper bits read zero
  localparam logic [7:0] IER_MASK = 8'h0F;
  localparam logic [7:0] MCR_MASK = 8'h1F;

  // identification codes, bit 0 low means pending
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LINE = 4'h6;
  localparam logic [3:0] IIR_RX = 4'h4;
  localparam logic [3:0] IIR_TX = 4'h2;
  localparam logic [3:0] IIR_MODEM = 4'h0;

  // reset values
  localparam logic [7:0] LSR_RESET = 8'h60;
  localparam logic [7:0] IIR_RESET = 8'h01;
  localparam logic [7:0] REG_ZERO = 8'h00;

  // oversampling: sixteen ticks a bit, sample in the middle
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'hF;

  // event bits of the sticky status register
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_LINE = 2;
  localparam int EV_MODEM = 3;

  typedef struct packed {
    logic [15:0] divisor;
    logic [1:0] charLen;
    logic stopTwo;
    logic parityOn;
    logic evenPar;
    logic stickPar;
    logic breakOn;
  } line_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parityErr;
    logic frameErr;
    logic breakErr;
  } rx_char_t;

  // data bits in a character, five to eight
  function automatic logic [3:0] dataBits(input line_cfg_t c);
    return 4'h5 + {2'b00, c.charLen};
  endfunction

  // parity bit that goes with a character
  function automatic logic parityBit(input logic [7:0] d, input line_cfg_t c);
    if (c.stickPar)
      return ~c.evenPar;
    return (^d) ^ ~c.evenPar;
  endfunction

  // keep only the active data bits
  function automatic logic [7:0] dataMask(input line_cfg_t c);
    return 8'hFF >> (4'h8 - dataBits(c));
  endfunction
endpackage

// ==== core/uart_serial.sv ====
`timescale 1ns/1ps
module uart_serial (
  input wire logic sys_clk,
  input wire logic rst_n,
  input uart_pkg::line_cfg_t cfg,
  input wire logic txLoad,
  input wire logic [7:0] txData,
  input wire logic rxIn,
  output logic txOut,
  output logic txBusy,
  output uart_pkg::rx_char_t rxChar
);
  typedef struct packed {
    logic [15:0] baudCnt;
    logic tick;
    logic txOn;
    logic [3:0] txSub;
    logic [3:0] txLeft;
    logic [11:0] txSh;
    logic rxOn;
    logic [3:0] rxSub;
    logic [3:0] rxCnt;
    logic [11:0] rxSh;
    uart_pkg::rx_char_t rxChar;
  } serial_state_t;

  serial_state_t s_q;
  serial_state_t s_d;

  // next state: baud tick, lsb-first shifter, mid-bit sampler
  always_comb begin
    logic [3:0] len;
    logic [3:0] total;
    logic [11:0] frame;
    logic [7:0] d;
    len = uart_pkg::dataBits(cfg);
    total = 4'h2 + len + {3'b000, cfg.parityOn};
    d = txData & uart_pkg::dataMask(cfg);
    frame = s_q.rxSh >> (4'hC - total);
    s_d = s_q;
    s_d.rxChar.valid = 1'b0;
    // divisor of zero behaves as one
    s_d.tick = (s_q.baudCnt + 16'h0001 >= cfg.divisor);
    s_d.baudCnt = s_d.tick ? 16'h0000 : s_q.baudCnt + 16'h0001;
    if (txLoad && !s_q.txOn) begin
      s_d.txSh = 12'hFFF;
      s_d.txSh[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < len)
          s_d.txSh[i + 1] = d[i];
      end
      if (cfg.parityOn)
        s_d.txSh[len + 4'h1] = uart_pkg::parityBit(d, cfg);
      s_d.txLeft = total + {3'b000, cfg.stopTwo};
      s_d.txSub = uart_pkg::SAMPLE_LAST;
      s_d.txOn = 1'b1;
    end else if (s_q.txOn && s_q.tick) begin
      s_d.txSub = s_q.txSub - 4'h1;
      if (s_q.txSub == 4'h0) begin
        s_d.txSh = {1'b1, s_q.txSh[11:1]};
        s_d.txLeft = s_q.txLeft - 4'h1;
        s_d.txOn = (s_q.txLeft != 4'h1);
      end
    end
    // receiver, start edge then one sample per bit time
    if (!s_q.rxOn) begin
      if (!rxIn) begin
        s_d.rxOn = 1'b1;
        s_d.rxSub = uart_pkg::SAMPLE_MID;
        s_d.rxCnt = 4'h0;
      end
    end else if (s_q.tick) begin
      s_d.rxSub = s_q.rxSub - 4'h1;
      if (s_q.rxSub == 4'h0) begin
        s_d.rxSub = uart_pkg::SAMPLE_LAST;
        s_d.rxSh = {rxIn, s_q.rxSh[11:1]};
        s_d.rxCnt = s_q.rxCnt + 4'h1;
        // a high start sample is a glitch, not a character
        if (s_q.rxCnt == 4'h0 && rxIn)
          s_d.rxOn = 1'b0;
        if (s_q.rxCnt + 4'h1 == total)
          s_d.rxOn = 1'b0;
      end
    end
    if (s_q.rxOn && !s_d.rxOn && s_q.rxCnt + 4'h1 == total) begin
      frame = s_d.rxSh >> (4'hC - total);
      s_d.rxChar.valid = 1'b1;
      s_d.rxChar.data = frame[8:1] & uart_pkg::dataMask(cfg);
      s_d.rxChar.parityErr = cfg.parityOn &&
        (frame[len + 4'h1] != uart_pkg::parityBit(s_d.rxChar.data, cfg));
      s_d.rxChar.frameErr = !frame[total - 4'h1];
      s_d.rxChar.breakErr = (frame == 12'h000);
    end
  end

  // single register stage for the whole engine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.txSh <= 12'hFFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign txOut = (s_q.txOn ? s_q.txSh[0] : 1'b1) & ~cfg.breakOn;
  assign txBusy = s_q.txOn;
  assign rxChar = s_q.rxChar;
endmodule // uart_serial

// ==== test/uart_channel_bench.sv ====
`timescale 1ns/1ps
module uart_channel_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic xtMode = 1'b0;
  logic [7:0] regRdata;
  logic rxd, ctsN, dsrN, riN, dcdN, txd, dtrN, rtsN, irq;
  int n_fail = 0;
  int check_count = 0;

  always #5 sys_clk = ~sys_clk;

  uart_channel u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .xtMode(xtMode), .rxd(rxd), .ctsN(ctsN), .dsrN(dsrN), .riN(riN),
    .dcdN(dcdN), .txd(txd), .dtrN(dtrN), .rtsN(rtsN), .irq(irq));
  uart_far_end u_far (.sys_clk(sys_clk), .txd(txd), .rxd(rxd), .ctsN(ctsN), .dsrN(dsrN), .riN(riN), .dcdN(dcdN));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  // bus cycles: one strobe cycle, then an idle cycle so strobes never get re-driven in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 q = regRdata; // data stands only in this cycle
    @(posedge sys_clk);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk(q, e);
  endtask

  // write then read with no gap: the read lands in the one cycle the holding byte waits
  task automatic wrrd(input logic [3:0] aw, input logic [7:0] d, input logic [3:0] ar, output logic [7:0] q);
    regAddr <= aw;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    rd(ar, q);
  endtask

  // bounded wait for status bits; running out ends the run
  task automatic poll(input logic [3:0] a, input logic [7:0] m);
    logic [7:0] q;
    for (int i = 0; i < 100; i++) begin
      rd(a, q);
      if ((q & m) === m) return;
    end
    $display("BAD t=%0t got=%h exp=%h", $time, q, m);
    n_fail++;
    end_sim();
  endtask

  task automatic t_reset();
    rdc(4'h5, 8'h60);
    rdc(4'h2, 8'h01);
    rdc(4'h1, 8'h00);
    rdc(4'h4, 8'h00);
    rdc(4'hB, 8'h00);
  endtask

  task automatic t_regs();
    wr(4'h1, 8'hFF);
    rdc(4'h1, 8'h0F);
    wr(4'h1, 8'h00);
    wr(4'h4, 8'hEC);
    rdc(4'h4, 8'h0C);
    chk({6'h00, dtrN, rtsN}, 8'h03);
    wr(4'h4, 8'h03);
    // pins are launched one edge after the write lands
    @(posedge sys_clk);
    chk({6'h00, dtrN, rtsN}, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h80);
    wr(4'h0, 8'h34);
    wr(4'h1, 8'h12);
    rdc(4'h0, 8'h34);
    rdc(4'h1, 8'h12);
    wr(4'h0, 8'h01); // fastest rate keeps frames short
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h03);
    rdc(4'h1, 8'h00);
  endtask

  task automatic t_queue();
    wr(4'h2, 8'hCF);
    rdc(4'h2, 8'hC1);
    rdc(4'h5, 8'h60);
    wr(4'h2, 8'h00);
    rdc(4'h2, 8'h01);
  endtask

  task automatic t_tx();
    logic [7:0] q;
    wrrd(4'h0, 8'hA5, 4'h5, q);
    chk(q, 8'h00);
    rdc(4'h0, 8'h00);
    poll(4'h5, 8'h40);
    chk(u_far.rxByte, 8'hA5);
  endtask

  task automatic t_rx_irq();
    wr(4'hA, 8'h01);
    u_far.sendFrame(8'h3C, 1'b1);
    poll(4'h5, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(4'hA, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(4'hA, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(4'h9, 8'h01);
    chk({7'h00, irq}, 8'h00);
    rdc(4'h8, 8'h02); // holding-to-shifter event of the earlier frame stays set
    rdc(4'h0, 8'h3C);
    rdc(4'h5, 8'h60);
    wr(4'hA, 8'h00);
  endtask

  task automatic t_prio();
    wr(4'h1, 8'h05);
    u_far.sendFrame(8'h81, 1'b0);
    // poll identification: a line state read would clear the fault under test
    poll(4'h2, 8'h06);
    rdc(4'h2, 8'h06);
    rdc(4'h5, 8'h69);
    rdc(4'h2, 8'h04);
    rdc(4'h0, 8'h81);
    rdc(4'h2, 8'h01);
    wr(4'h1, 8'h02);
    rdc(4'h2, 8'h02);
    rdc(4'h2, 8'h01);
    wr(4'h1, 8'h00);
  endtask

  task automatic t_xt();
    logic [7:0] q;
    wr(4'h7, 8'h5A);
    rdc(4'h7, 8'h5A);
    xtMode <= 1'b1;
    wr(4'h7, 8'h33);
    rdc(4'h7, 8'h00);
    // holding full, shifter still idle: only xt mode reports idle here
    wrrd(4'h0, 8'hC3, 4'h5, q);
    chk(q, 8'h40);
    rdc(4'h5, 8'h20);
    poll(4'h5, 8'h40);
    chk(u_far.rxByte, 8'hC3);
    xtMode <= 1'b0;
    rdc(4'h7, 8'h5A);
  endtask

  // cts goes active: delta and level, delta clears on read
  task automatic t_modem();
    u_far.modemN <= 4'hE;
    poll(4'h6, 8'h11);
    rdc(4'h6, 8'h10);
    u_far.modemN <= 4'hF;
    // loop mode: control bit 0 feeds set-ready, pins parked inactive
    wr(4'h4, 8'h11);
    rdc(4'h6, 8'h23);
    chk({6'h00, dtrN, rtsN}, 8'h03);
    wr(4'h4, 8'h00);
  endtask

  // second reset in mid-run must restore the reset picture
  task automatic t_reset_again();
    wr(4'h7, 8'h77);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(4'h5, 8'h60);
    rdc(4'h2, 8'h01);
    rdc(4'h7, 8'h00);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_queue();
    t_tx();
    t_rx_irq();
    t_prio();
    t_xt();
    t_modem();
    t_reset_again();
    end_sim();
  end
endmodule // uart_channel_bench

// ==== test/uart_channel_chk.sv ====
`timescale 1ns/1ps
module uart_channel_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic xtMode,
  input wire logic dtrN,
  input wire logic rtsN,
  input wire logic irq
);
  logic divAcc_q;
  logic fifoOn_q;
  logic [7:0] scr_q;
  logic rdIir;
  logic rdScr;

  // shadow of bank select, queue enable and scratch, as seen on the bus
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divAcc_q <= 1'b0;
      fifoOn_q <= 1'b0;
      scr_q <= 8'h00;
    end else if (regWr) begin
      if (regAddr == uart_pkg::ADDR_LCR) divAcc_q <= regWdata[7];
      if (regAddr == uart_pkg::ADDR_IIR) fifoOn_q <= regWdata[0];
      if (regAddr == uart_pkg::ADDR_SCR && !xtMode) scr_q <= regWdata; // xt writes are dropped
    end
  end

  // read strobes of interest
  assign rdIir = regRd && regAddr == uart_pkg::ADDR_IIR;
  assign rdScr = regRd && regAddr == uart_pkg::ADDR_SCR;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  iir_zero_bits_a: assert property (rdIir |=> regRdata[5:4] == 2'b00)
    else $error("identification bits 5:4 not zero");
  iir_queue_flag_a: assert property (rdIir |=> regRdata[7:6] == {2{fifoOn_q}})
    else $error("identification queue flags wrong");
  iir_noqueue_a: assert property (rdIir && !fifoOn_q |=> !regRdata[3] && regRdata[7:6] == 2'b00)
    else $error("queue-only identification bits set");
  lsr_queue_err_a: assert property (regRd && regAddr == uart_pkg::ADDR_LSR && !fifoOn_q |=> !regRdata[7])
    else $error("line state bit 7 set without queues");
  ier_upper_zero_a: assert property (regRd && regAddr == uart_pkg::ADDR_IER && !divAcc_q |=> regRdata[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  mcr_upper_zero_a: assert property (regRd && regAddr == uart_pkg::ADDR_MCR |=> regRdata[7:5] == 3'h0)
    else $error("modem control upper bits not zero");
  scratch_absent_a: assert property (rdScr && xtMode |=> regRdata == 8'h00)
    else $error("scratch visible in xt mode");
  scratch_keeps_a: assert property (rdScr && !xtMode |=> regRdata == scr_q)
    else $error("scratch lost its value");
  pins_follow_a: assert property (regWr && regAddr == uart_pkg::ADDR_MCR && !regWdata[4]
    |=> ##1 dtrN == !$past(regWdata[0], 2) && rtsN == !$past(regWdata[1], 2))
    else $error("modem pins do not follow control bits 0 and 1");

  // main scenarios reached
  cover property (rdIir ##1 regRdata[3:0] == 4'h6);
  cover property (regWr && regAddr == uart_pkg::ADDR_DATA && !divAcc_q);
  cover property ($rose(irq));
endmodule // uart_channel_chk

bind uart_channel uart_channel_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .xtMode(xtMode), .dtrN(dtrN), .rtsN(rtsN), .irq(irq));

// ==== test/uart_far_end.sv ====
`timescale 1ns/1ps
module uart_far_end #(
  parameter int BIT_CYC = 16
) (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd,
  output logic ctsN,
  output logic dsrN,
  output logic riN,
  output logic dcdN
);
  logic [7:0] rxByte = 8'h00;
  logic [3:0] modemN = 4'hF;

  // modem lines idle inactive; the bench moves them
  assign {dcdN, riN, dsrN, ctsN} = modemN;
  initial rxd = 1'b1;

  // receiver: center sampling, first bit on the wire lands in bit 0
  initial forever begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      rxByte[i] = txd;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
  end

  // one 8-bit frame, no parity; a low stop gives a framing fault
  task automatic sendFrame(input logic [7:0] b, input logic stopLvl);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    rxd <= stopLvl;
    repeat (BIT_CYC) @(posedge sys_clk);
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask
endmodule // uart_far_end
